/* File: src/dcm_pkg.sv */
// package for the ddr2 command-mode burst block
package dcm_pkg;
    localparam int DCM_ROW_W   = 13;
    localparam int DCM_COL_W   = 10;
    localparam int DCM_BANK_W  = 3;
    localparam int DCM_NBANK   = 4;
    localparam int DCM_DQ_W    = 8;
    localparam int DCM_CFG_W   = 13;
    // configuration field positions
    localparam int DCM_CFG_BL_LSB   = 0;
    localparam int DCM_CFG_BT_BIT   = 3;
    localparam int DCM_CFG_RL_LSB   = 4;
    localparam int DCM_CFG_DLLR_BIT = 8;
    localparam int DCM_CFG_WR_LSB   = 9;
    localparam int DCM_CFG_PD_BIT   = 12;
    localparam int DCM_ADDR_AP_BIT  = 10;
    localparam logic [2:0] DCM_BL_FOUR  = 3'h2;
    localparam logic [2:0] DCM_BL_EIGHT = 3'h3;
    localparam logic [12:0] DCM_CFG_RESET = 13'h0032;
    // timing
    localparam int DCM_CLK_PERIOD_NS = 10;
    localparam int DCM_TRP_NS        = 15;
    localparam int DCM_REGISTER_LOAD_DELAY_CK       = 2;
    localparam int DCM_TRP_CK =
        (DCM_TRP_NS + DCM_CLK_PERIOD_NS - 1) / DCM_CLK_PERIOD_NS;
    localparam int DCM_SELF_DLL_CK   = 200;
    localparam int DCM_FIFO_DEPTH    = 16;

    typedef enum logic [2:0] {
        DCM_CMD_NOP   = 3'h7,
        DCM_CMD_ACT   = 3'h3,
        DCM_CMD_READ  = 3'h5,
        DCM_CMD_WRITE = 3'h4,
        DCM_CMD_PRE   = 3'h2,
        DCM_CMD_REF   = 3'h1,
        DCM_CMD_LOAD  = 3'h0
    } dcm_cmd_t;

    // one write beat as it enters the buffer
    typedef struct packed {
        logic [DCM_BANK_W-1:0] bank;
        logic [DCM_COL_W-1:0]  col;
        logic                  mask;
        logic [DCM_DQ_W-1:0]   data;
    } dcm_beat_t;

    // column access issued to the array
    typedef struct packed {
        logic [DCM_BANK_W-1:0] bank;
        logic [DCM_COL_W-1:0]  col;
        logic [DCM_DQ_W-1:0]   data;
    } dcm_access_t;
endpackage

/* File: src/dcm_fifo.sv */
// small synchronous fifo for write beats
`timescale 1ns/100ps
`default_nettype none
module dcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wptr_reg;
    logic [AW:0]      rptr_reg;
    logic [AW:0]      count_w;
    logic             push_w;
    logic             pop_w;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             have_w;

    // occupancy and handshakes
    assign count_w   = wptr_reg - rptr_reg;
    assign have_w    = count_w != '0;
    assign in_ready  = count_w < (AW+1)'(DEPTH);
    assign push_w    = in_valid && in_ready;
    assign pop_w     = have_w && (!out_valid_reg || out_ready);
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    // storage and registered read port
    always_ff @(posedge ref_clk) begin
        if (push_w) begin
            mem_reg[wptr_reg[AW-1:0]] <= in_data;
        end
        if (pop_w) begin
            out_data_reg <= mem_reg[rptr_reg[AW-1:0]];
        end
    end

    // pointers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wptr_reg      <= '0;
            rptr_reg      <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            if (push_w) wptr_reg <= wptr_reg + 1'b1;
            if (pop_w) rptr_reg <= rptr_reg + 1'b1;
            if (pop_w) out_valid_reg <= 1'b1;
            else if (out_ready) out_valid_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: src/dcm_core.sv */
// ddr2 command decode, configuration register, bank state and write bursts
//
// Contract
// - write targets an open row; bank inputs pick bank, low address gives column
// - address bit 10 on a write closes the row after the burst
// - column commands take effect after the posted latency clocks; only writes are decoded, reads are ignored
// - a beat is stored only when its mask is sampled low
// - precharge closes one bank or all; reopen waits the precharge time
// - a precharged bank is idle and refuses column accesses
// - precharge to idle bank is legal; period timed from the last one
// - one refresh per command, row address internal, address ignored
// - refresh with clock enable low enters self refresh
// - loop turned off in self refresh, back on at exit
// - configuration holds until reloaded; loop-reset bit clears itself
// - three-bit burst length field selects four or eight
// - burst wraps inside an aligned block of four or eight columns
// - one burst length serves reads and writes
// - one bit picks sequential or interleaved order
// - sequential order counts low two bits, then the other nibble
// - interleaved order is start offset xor beat index
// - bits 4 to 6 hold read latency
// - bits 9 to 11 hold write recovery before auto precharge
// - writing one to bit 8 resets the loop
// - bit 12 selects fast or slow power-down exit; the core stores it but has no power-down
`timescale 1ns/100ps
`default_nettype none
module dcm_core
    import dcm_pkg::*;
#(
    parameter int POSTED_LATENCY = 0,
    parameter int MAX_POSTED     = 7
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  cke,
    input  wire dcm_cmd_t              cmd,
    input  wire logic [DCM_BANK_W-1:0] bank_sel,
    input  wire logic [DCM_ROW_W-1:0]  addr,
    input  wire logic [DCM_DQ_W-1:0]   wr_data,
    input  wire logic                  wr_mask,
    output logic                       wr_ready,
    input  wire logic                  array_ready,
    output logic                       array_valid,
    output dcm_access_t                array_access,
    output logic [DCM_CFG_W-1:0]       cfg_out,
    output logic [DCM_NBANK-1:0]       bank_open,
    output logic                       self_refresh,
    output logic                       dll_on,
    output logic                       refresh_pulse,
    output logic                       cmd_error
);
    typedef enum logic [1:0] {
        DCM_ST_IDLE  = 2'b00,
        DCM_ST_BURST = 2'b01,
        DCM_ST_SELF  = 2'b10
    } dcm_state_t;

    localparam int PW = $clog2(MAX_POSTED + 2);

    // pin synchronisers
    logic        cke_s1_reg, cke_s2_reg;
    dcm_cmd_t    cmd_s1_reg, cmd_s2_reg;
    logic [DCM_BANK_W-1:0] ba_s1_reg, ba_s2_reg;
    logic [DCM_ROW_W-1:0]  ad_s1_reg, ad_s2_reg;
    logic [DCM_DQ_W-1:0]   dq_s1_reg, dq_s2_reg;
    logic        dm_s1_reg, dm_s2_reg;

    always_ff @(posedge ref_clk) begin
        cke_s1_reg <= cke;
        cke_s2_reg <= cke_s1_reg;
        cmd_s1_reg <= cmd;
        cmd_s2_reg <= cmd_s1_reg;
        ba_s1_reg  <= bank_sel;
        ba_s2_reg  <= ba_s1_reg;
        ad_s1_reg  <= addr;
        ad_s2_reg  <= ad_s1_reg;
        dq_s1_reg  <= wr_data;
        dq_s2_reg  <= dq_s1_reg;
        dm_s1_reg  <= wr_mask;
        dm_s2_reg  <= dm_s1_reg;
    end

    // registers
    dcm_state_t            state_reg, state_next;
    logic [DCM_CFG_W-1:0]  cfg_reg;
    logic [DCM_NBANK-1:0]  open_reg;
    logic [DCM_NBANK-1:0]  ap_pend_reg;
    logic [7:0]            trp_cnt_reg [DCM_NBANK];
    logic [3:0]            mrd_cnt_reg;
    logic [7:0]            dll_cnt_reg;
    logic                  dll_on_reg;
    logic                  refresh_reg;
    logic                  error_reg;
    logic [2:0]            beat_reg;
    logic [DCM_BANK_W-1:0] burst_bank_reg;
    logic [DCM_COL_W-1:0]  burst_col_reg;
    logic                  burst_ap_reg;
    logic [3:0]            wrec_cnt_reg;
    logic [DCM_BANK_W-1:0] wrec_bank_reg;
    // posted-latency delay line for write commands
    logic [PW-1:0]         post_cnt_reg;
    logic                  post_busy_reg;
    logic [DCM_BANK_W-1:0] post_bank_reg;
    logic [DCM_COL_W-1:0]  post_col_reg;
    logic                  post_ap_reg;

    // decoded fields
    logic       cmd_live_w;
    logic       is_write_w, is_pre_w, is_ref_w, is_load_w;
    logic       is_self_w;
    logic [1:0] bidx_w;
    logic       bl8_w;
    logic       seq_w;
    logic [2:0] last_beat_w;
    logic [3:0] wr_clk_w;
    logic       bank_ok_w;
    logic       start_w;
    logic       beat_go_w;
    logic [2:0] offs_w;
    logic [2:0] step_w;
    logic [2:0] ord_w;
    logic       burst_end_w;

    assign cmd_live_w = cke_s2_reg && mrd_cnt_reg == '0
                        && state_reg != DCM_ST_SELF;
    assign is_write_w = cmd_live_w && cmd_s2_reg == DCM_CMD_WRITE;
    assign is_pre_w   = cmd_live_w && cmd_s2_reg == DCM_CMD_PRE;
    assign is_ref_w   = cmd_live_w && cmd_s2_reg == DCM_CMD_REF;
    assign is_load_w  = cmd_live_w && cmd_s2_reg == DCM_CMD_LOAD
                        && ba_s2_reg == '0;
    assign is_self_w  = !cke_s2_reg && cmd_s2_reg == DCM_CMD_REF
                        && state_reg == DCM_ST_IDLE;
    assign bidx_w     = ba_s2_reg[1:0];

    // burst configuration decode
    assign bl8_w = cfg_reg[DCM_CFG_BL_LSB +: 3] == DCM_BL_EIGHT;
    assign seq_w = !cfg_reg[DCM_CFG_BT_BIT];
    assign last_beat_w = bl8_w ? 3'h7 : 3'h3;
    assign wr_clk_w = {1'b0, cfg_reg[DCM_CFG_WR_LSB +: 3]} + 4'h1;
    assign bank_ok_w = open_reg[post_bank_reg[1:0]];

    // posted command lands in the array once its latency has elapsed
    assign start_w = post_busy_reg && post_cnt_reg == '0
                     && state_reg == DCM_ST_IDLE;
    assign beat_go_w = state_reg == DCM_ST_BURST && wr_ready;
    assign burst_end_w = beat_go_w && beat_reg == last_beat_w;

    // column ordering within a burst
    assign offs_w = burst_col_reg[2:0];
    assign step_w = seq_w
        ? (bl8_w ? {offs_w[2] ^ beat_reg[2], offs_w[1:0] + beat_reg[1:0]}
                 : {offs_w[2], offs_w[1:0] + beat_reg[1:0]})
        : (bl8_w ? offs_w ^ beat_reg
                 : {offs_w[2], offs_w[1:0] ^ beat_reg[1:0]});
    assign ord_w = step_w;

    // beat buffer
    dcm_beat_t   beat_in_w;
    dcm_beat_t   beat_out_w;
    logic        fifo_in_valid_w;
    logic        fifo_out_valid_w;
    logic        fifo_out_ready_w;

    assign beat_in_w.bank = burst_bank_reg;
    assign beat_in_w.col  = {burst_col_reg[DCM_COL_W-1:3], ord_w};
    assign beat_in_w.mask = dm_s2_reg;
    assign beat_in_w.data = dq_s2_reg;
    assign fifo_in_valid_w = beat_go_w && !dm_s2_reg;
    assign fifo_out_ready_w = !array_valid || array_ready;

    dcm_fifo #(
        .WIDTH ($bits(dcm_beat_t)),
        .DEPTH (DCM_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (fifo_in_valid_w),
        .in_ready  (wr_ready),
        .in_data   (beat_in_w),
        .out_valid (fifo_out_valid_w),
        .out_ready (fifo_out_ready_w),
        .out_data  (beat_out_w)
    );

    // state sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            DCM_ST_IDLE: begin
                if (is_self_w) state_next = DCM_ST_SELF;
                else if (start_w && bank_ok_w) state_next = DCM_ST_BURST;
            end
            DCM_ST_BURST: begin
                if (burst_end_w) state_next = DCM_ST_IDLE;
            end
            DCM_ST_SELF: begin
                if (cke_s2_reg) state_next = DCM_ST_IDLE;
            end
            default: state_next = DCM_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) state_reg <= DCM_ST_IDLE;
        else state_reg <= state_next;
    end

    // configuration register load, loop-reset bit self clears
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_reg     <= DCM_CFG_RESET;
            mrd_cnt_reg <= '0;
        end else if (is_load_w) begin
            cfg_reg     <= ad_s2_reg;
            mrd_cnt_reg <= 4'(DCM_REGISTER_LOAD_DELAY_CK);
        end else begin
            cfg_reg[DCM_CFG_DLLR_BIT] <= 1'b0;
            if (mrd_cnt_reg != '0) mrd_cnt_reg <= mrd_cnt_reg - 4'h1;
        end
    end

    // loop enable: off in self refresh, relock after reset or exit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dll_on_reg  <= 1'b1;
            dll_cnt_reg <= '0;
        end else if (state_reg == DCM_ST_SELF) begin
            dll_on_reg  <= cke_s2_reg;
            dll_cnt_reg <= 8'(DCM_SELF_DLL_CK);
        end else if (cfg_reg[DCM_CFG_DLLR_BIT]) begin
            dll_cnt_reg <= 8'(DCM_SELF_DLL_CK);
        end else if (dll_cnt_reg != '0) begin
            dll_cnt_reg <= dll_cnt_reg - 8'h1;
        end
    end

    // posted write delay line
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            post_busy_reg <= 1'b0;
            post_cnt_reg  <= '0;
            post_bank_reg <= '0;
            post_col_reg  <= '0;
            post_ap_reg   <= 1'b0;
        end else if (is_write_w && !post_busy_reg) begin
            post_busy_reg <= 1'b1;
            post_cnt_reg  <= PW'(POSTED_LATENCY);
            post_bank_reg <= ba_s2_reg;
            post_col_reg  <= ad_s2_reg[DCM_COL_W-1:0];
            post_ap_reg   <= ad_s2_reg[DCM_ADDR_AP_BIT];
        end else if (post_busy_reg && post_cnt_reg != '0) begin
            post_cnt_reg <= post_cnt_reg - 1'b1;
        end else if (start_w) begin
            post_busy_reg <= 1'b0;
        end
    end

    // burst tracking
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            beat_reg       <= '0;
            burst_bank_reg <= '0;
            burst_col_reg  <= '0;
            burst_ap_reg   <= 1'b0;
        end else if (start_w) begin
            beat_reg       <= '0;
            burst_bank_reg <= post_bank_reg;
            burst_col_reg  <= post_col_reg;
            burst_ap_reg   <= post_ap_reg;
        end else if (beat_go_w) begin
            beat_reg <= beat_reg + 3'h1;
        end
    end

    // bank rows, precharge timing and auto precharge after recovery
    genvar gi;
    for (gi = 0; gi < DCM_NBANK; gi++) begin : g_bank
        logic hit_pre_w, hit_ap_w;
        assign hit_pre_w = is_pre_w && (ad_s2_reg[DCM_ADDR_AP_BIT]
                           || bidx_w == 2'(gi));
        assign hit_ap_w = ap_pend_reg[gi] && wrec_cnt_reg == '0
                          && wrec_bank_reg[1:0] == 2'(gi);
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                open_reg[gi]    <= 1'b0;
                ap_pend_reg[gi] <= 1'b0;
                trp_cnt_reg[gi] <= '0;
            end else begin
                if (burst_end_w && burst_ap_reg
                        && burst_bank_reg[1:0] == 2'(gi)) begin
                    ap_pend_reg[gi] <= 1'b1;
                end else if (hit_ap_w) begin
                    ap_pend_reg[gi] <= 1'b0;
                end
                if (hit_pre_w || hit_ap_w) begin
                    open_reg[gi]    <= 1'b0;
                    trp_cnt_reg[gi] <= 8'(DCM_TRP_CK);
                end else begin
                    if (cmd_live_w && cmd_s2_reg == DCM_CMD_ACT
                            && bidx_w == 2'(gi)
                            && trp_cnt_reg[gi] == '0) begin
                        open_reg[gi] <= 1'b1;
                    end
                    if (trp_cnt_reg[gi] != '0) begin
                        trp_cnt_reg[gi] <= trp_cnt_reg[gi] - 8'h1;
                    end
                end
            end
        end
    end

    // write recovery timer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wrec_cnt_reg  <= '0;
            wrec_bank_reg <= '0;
        end else if (burst_end_w && burst_ap_reg) begin
            wrec_cnt_reg  <= wr_clk_w;
            wrec_bank_reg <= burst_bank_reg;
        end else if (wrec_cnt_reg != '0) begin
            wrec_cnt_reg <= wrec_cnt_reg - 4'h1;
        end
    end

    // refresh pulse, error flag, array output
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            refresh_reg  <= 1'b0;
            error_reg    <= 1'b0;
            array_valid  <= 1'b0;
            array_access <= '0;
        end else begin
            refresh_reg <= is_ref_w && open_reg == '0;
            if (start_w && !bank_ok_w) error_reg <= 1'b1;
            else if (is_load_w && open_reg != '0) error_reg <= 1'b1;
            if (fifo_out_ready_w) begin
                array_valid <= fifo_out_valid_w;
                array_access.bank <= beat_out_w.bank;
                array_access.col  <= beat_out_w.col;
                array_access.data <= beat_out_w.data;
            end
        end
    end

    assign cfg_out       = cfg_reg;
    assign bank_open     = open_reg;
    assign self_refresh  = state_reg[1]; // only the self state sets bit 1
    assign dll_on        = dll_on_reg;
    assign refresh_pulse = refresh_reg;
    assign cmd_error     = error_reg;
endmodule
`default_nettype wire

/* File: sim/dcm_core_chk.sv */
// concurrent checks on the command core ports
`timescale 1ns/100ps
`default_nettype none
module dcm_core_chk
    import dcm_pkg::*;
(
    input wire logic                 ref_clk,
    input wire logic                 srst,
    input wire logic                 cke,
    input wire dcm_cmd_t             cmd,
    input wire logic [DCM_ROW_W-1:0] addr,
    input wire logic                 array_valid,
    input wire logic                 array_ready,
    input wire dcm_access_t          array_access,
    input wire logic [DCM_CFG_W-1:0] cfg_out,
    input wire logic [DCM_NBANK-1:0] bank_open,
    input wire logic                 self_refresh,
    input wire logic                 dll_on,
    input wire logic                 refresh_pulse,
    input wire logic                 cmd_error
);
    // one clock domain, reset disables every check
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // reset state and configuration
    a_reset_state: assert property ($fell(srst) |->
        cfg_out == DCM_CFG_RESET && bank_open == '0 && dll_on)
        else $error("state wrong after reset");
    a_cfg_only_load: assert property (
        ($changed(cfg_out[7:0]) || $changed(cfg_out[12:9])) |->
        ($past(cmd, 2) == DCM_CMD_LOAD || $past(cmd, 3) == DCM_CMD_LOAD
        || $past(cmd, 4) == DCM_CMD_LOAD))
        else $error("configuration changed without a load");
    a_dll_bit_clears: assert property (cfg_out[DCM_CFG_DLLR_BIT] |->
        ##[1:4] !cfg_out[DCM_CFG_DLLR_BIT])
        else $error("loop reset bit stuck");
    // refresh and self refresh
    a_refresh_once: assert property (refresh_pulse |=> !refresh_pulse)
        else $error("refresh pulse too long");
    a_refresh_fires: assert property ((cmd == DCM_CMD_REF && cke
        && bank_open == '0 && !self_refresh) ##1 cke |-> ##[1:5] refresh_pulse)
        else $error("refresh not performed");
    a_sref_entry: assert property ((cmd == DCM_CMD_REF && !cke
        && bank_open == '0 && !self_refresh) ##1 !cke |-> ##[1:5] self_refresh)
        else $error("self refresh not entered");
    a_sref_dll_off: assert property ($rose(self_refresh) |->
        ##[0:2] !dll_on)
        else $error("loop still on in self refresh");
    a_sref_dll_on: assert property ($fell(self_refresh) |->
        ##[0:300] dll_on)
        else $error("loop not back on after self refresh");
    // bank state and data path
    a_pre_all_closes: assert property ((cmd == DCM_CMD_PRE && cke
        && addr[DCM_ADDR_AP_BIT] && !self_refresh) |-> ##[2:5] bank_open == '0)
        else $error("precharge all left a row open");
    a_error_sticky: assert property (cmd_error |=> cmd_error)
        else $error("error flag dropped");
    a_access_hold: assert property (array_valid && !array_ready |=>
        array_valid && $stable(array_access))
        else $error("access changed while stalled");

    // main scenarios reached
    c_sref: cover property ($rose(self_refresh));
    c_refresh: cover property (refresh_pulse);
    c_access: cover property (array_valid && array_ready);
    c_error: cover property ($rose(cmd_error));
endmodule
bind dcm_core dcm_core_chk u_chk (.ref_clk(ref_clk), .srst(srst),
    .cke(cke), .cmd(cmd), .addr(addr), .array_valid(array_valid),
    .array_ready(array_ready), .array_access(array_access),
    .cfg_out(cfg_out), .bank_open(bank_open),
    .self_refresh(self_refresh), .dll_on(dll_on),
    .refresh_pulse(refresh_pulse), .cmd_error(cmd_error));
`default_nettype wire

/* File: sim/dcm_ctl_model.sv */
// far-side controller model driving commands and write beats
`timescale 1ns/100ps
`default_nettype none
module dcm_ctl_model
    import dcm_pkg::*;
(
    input  wire logic             ref_clk,
    output logic                  cke,
    output dcm_cmd_t              cmd,
    output logic [DCM_BANK_W-1:0] bank_sel,
    output logic [DCM_ROW_W-1:0]  addr,
    output logic [DCM_DQ_W-1:0]   wr_data,
    output logic                  wr_mask
);
    // quiet pins at time zero
    initial begin
        cke = 1'b1;
        cmd = DCM_CMD_NOP;
        bank_sel = 3'h0;
        addr = 13'h0;
        wr_data = 8'h0;
        wr_mask = 1'b1;
    end
    // one command in one cycle; loads always carry the full word
    task automatic issue(input dcm_cmd_t c, input logic [2:0] b,
                         input logic [12:0] a, input logic e = 1'b1);
        @(negedge ref_clk);
        cke = e;
        cmd = c;
        bank_sel = {1'b0, b[1:0]};
        addr = a;
    endtask
    // nop cycles; address and bank lines no longer hold the old value
    task automatic idle(input int n);
        @(negedge ref_clk);
        cmd = DCM_CMD_NOP;
        addr = ~addr;
        bank_sel = ~bank_sel;
        repeat (n - 1) @(negedge ref_clk);
    endtask
    task automatic wake;
        @(negedge ref_clk);
        cke = 1'b1;
    endtask
    // write command to bank 1 and its beats, the beat at index skip masked
    task automatic burst(input int n, input logic [12:0] a,
                         input logic [7:0] d0, input int skip);
        issue(DCM_CMD_WRITE, 3'h1, a);
        idle(1); // first beat two clocks after the command
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            cmd = DCM_CMD_NOP;
            wr_data = d0 + 8'(i);
            wr_mask = (i == skip);
        end
        idle(1);
        wr_data = ~wr_data;
        wr_mask = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the command core
`timescale 1ns/100ps
`default_nettype none
module tb
    import dcm_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic        array_ready = 1'b0;
    logic        cke, wr_mask, wr_ready, array_valid;
    logic        self_refresh, dll_on, refresh_pulse, cmd_error;
    dcm_cmd_t    cmd;
    logic [2:0]  bank_sel;
    logic [12:0] addr, cfg_out;
    logic [7:0]  wr_data;
    logic [3:0]  bank_open;
    dcm_access_t array_access;
    dcm_access_t seen[$];
    int          errors = 0;
    int          checked = 0;
    int          cnt = 0;

    dcm_core dut (.ref_clk(ref_clk), .srst(srst), .cke(cke), .cmd(cmd),
        .bank_sel(bank_sel), .addr(addr), .wr_data(wr_data),
        .wr_mask(wr_mask), .wr_ready(wr_ready),
        .array_ready(array_ready), .array_valid(array_valid),
        .array_access(array_access), .cfg_out(cfg_out),
        .bank_open(bank_open), .self_refresh(self_refresh),
        .dll_on(dll_on), .refresh_pulse(refresh_pulse),
        .cmd_error(cmd_error));
    dcm_ctl_model ctl (.ref_clk(ref_clk), .cke(cke), .cmd(cmd),
        .bank_sel(bank_sel), .addr(addr), .wr_data(wr_data),
        .wr_mask(wr_mask));

    always #5 ref_clk = ~ref_clk;
    // array sink stalls one cycle in three
    always @(negedge ref_clk) begin
        cnt <= cnt + 1;
        array_ready <= (cnt % 3 != 2);
    end
    always @(posedge ref_clk)
        if (array_valid === 1'b1 && array_ready)
            seen.push_back(array_access);

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %0h not %0h", $time, what,
                got, exp);
        end
    endtask
    task automatic conclude;
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // column of beat i inside its aligned block
    function automatic logic [9:0] ecol(int bl, logic bt, logic [9:0] s,
                                        int i);
        logic [9:0] m;
        m = 10'(bl - 1);
        if (bt)
            return (s & ~m) | ((s ^ 10'(i)) & m);
        return (s & ~m) | ((s & m & 10'h4) ^ (10'(i) & 10'h4))
            | ((s + 10'(i)) & 10'h3);
    endfunction

    // load, open bank 1, write one burst and compare the accesses
    task automatic t_burst(input logic [2:0] blc, input logic bt,
                           input logic [9:0] s, input logic ap);
        logic [12:0] cfg;
        int bl;
        int k;
        bl = (blc == DCM_BL_EIGHT) ? 8 : 4;
        cfg = {1'b0, 3'h1, 1'b0, 1'b0, 3'h3, bt, blc};
        ctl.issue(DCM_CMD_LOAD, 3'h0, cfg);
        ctl.idle(8);
        check(cfg_out, cfg, "cfg");
        ctl.issue(DCM_CMD_ACT, 3'h1, 13'h0123);
        ctl.idle(6);
        check(bank_open[1], 1'b1, "open");
        seen.delete();
        ctl.burst(bl, {2'h0, ap, s}, 8'h40, 1);
        ctl.issue(DCM_CMD_ACT, 3'h2, 13'h0042);
        for (k = 0; k < 80 && seen.size() < bl - 1; k++)
            @(posedge ref_clk);
        check(seen.size(), bl - 1, "beats");
        k = 0;
        for (int i = 0; i < bl && k < seen.size(); i++)
            if (i != 1) begin
                check(seen[k].col, ecol(bl, bt, s, i), "col");
                check(seen[k].data, 8'h40 + 8'(i), "data");
                check(seen[k].bank, 3'h1, "bank");
                k++;
            end
        ctl.idle(12);
        check(bank_open[1], !ap, "auto close");
        check(bank_open[2], 1'b1, "other bank");
        ctl.issue(DCM_CMD_PRE, 3'h1, 13'h0400);
        ctl.idle(6);
    endtask
    task automatic t_dll;
        ctl.issue(DCM_CMD_LOAD, 3'h0, 13'h0132);
        ctl.idle(10);
        check(cfg_out, 13'h0032, "loop bit");
    endtask
    task automatic t_pre;
        ctl.issue(DCM_CMD_ACT, 3'h0, 13'h0011);
        ctl.issue(DCM_CMD_ACT, 3'h2, 13'h0022);
        ctl.idle(6);
        check(bank_open, 4'h5, "two open");
        ctl.issue(DCM_CMD_PRE, 3'h0, 13'h0400);
        ctl.idle(6);
        check(bank_open, 4'h0, "pre all");
        ctl.issue(DCM_CMD_PRE, 3'h3, 13'h0);
        ctl.issue(DCM_CMD_ACT, 3'h3, 13'h0);
        ctl.idle(6);
        check(bank_open[3], 1'b0, "act early");
        check(cmd_error, 1'b0, "pre idle");
        ctl.issue(DCM_CMD_ACT, 3'h3, 13'h0);
        ctl.idle(6);
        check(bank_open[3], 1'b1, "act late");
        ctl.issue(DCM_CMD_PRE, 3'h3, 13'h0);
        ctl.idle(6);
    endtask
    task automatic t_refresh;
        int n;
        int k;
        n = 0;
        ctl.issue(DCM_CMD_REF, 3'h2, 13'h1fff);
        ctl.idle(1);
        repeat (10) begin
            @(posedge ref_clk);
            #1 if (refresh_pulse === 1'b1) n++;
        end
        check(n, 1, "refresh count");
        ctl.issue(DCM_CMD_REF, 3'h0, 13'h0, 1'b0);
        ctl.idle(10);
        check(self_refresh, 1'b1, "sref on");
        check(dll_on, 1'b0, "loop off");
        ctl.wake();
        for (k = 0; k < 300 && dll_on !== 1'b1; k++)
            @(negedge ref_clk);
        check(dll_on, 1'b1, "loop on");
        check(self_refresh, 1'b0, "sref off");
    endtask
    task automatic t_closed;
        seen.delete();
        ctl.burst(4, 13'h0000, 8'h00, 9);
        ctl.idle(6);
        check(cmd_error, 1'b1, "closed write");
        check(seen.size(), 0, "no access");
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        check(cfg_out, DCM_CFG_RESET, "reset cfg");
        check(bank_open, 4'h0, "reset banks");
        check(dll_on, 1'b1, "reset loop");
        check(wr_ready, 1'b1, "buffer room");
        for (int c = 0; c < 8; c++)
            t_burst(c[2] ? DCM_BL_EIGHT : DCM_BL_FOUR, c[1],
                c[0] ? 10'h00d : 10'h006, c[0]);
        t_dll();
        t_pre();
        t_refresh();
        t_closed();
        conclude();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        conclude();
    end
endmodule
`default_nettype wire
